// ---- design/lbe_regs.svh ----
// Register offsets, bit positions, reset values and timing counts
// of the board error status block.
// Assumes inclusion by bare name from the detector, the token monitor, the top module and the bench.
`ifndef LBE_REGS_SVH
`define LBE_REGS_SVH

// Register offsets on the plain register port
`define LBE_ADDR_W          8
`define LBE_DATA_W          16
`define LBE_OFS_ERR_WORD    8'h00
`define LBE_OFS_SUMMARY     8'h04
`define LBE_OFS_CTRL        8'h08
`define LBE_OFS_MON_TIME    8'h0C
`define LBE_OFS_INT_STAT    8'h10
`define LBE_OFS_INT_MASK    8'h14

// Error word bit positions
`define LBE_BIT_WATCHDOG    0
`define LBE_BIT_BUS         1
`define LBE_BIT_CYCLIC      2
`define LBE_BIT_DATA        3
`define LBE_BIT_HOST        4
`define LBE_BIT_LOAD        8
`define LBE_BIT_OPCYC       9
`define LBE_FATAL_LSB       0
`define LBE_FATAL_MSB       3
`define LBE_NONFATAL_LSB    4
`define LBE_NONFATAL_MSB    15

// Summary and control bit positions
`define LBE_SUM_FATAL       0
`define LBE_SUM_NONFATAL    1
`define LBE_CTRL_CLEAR      0

// Reset values
`define LBE_MON_TIME_RST    16'h0064
`define LBE_INT_MASK_RST    16'h0000

// Thresholds
`define LBE_LOAD_LIMIT_PCT  8'h50
`define LBE_HOST_LIMIT_PCT  8'h1E
`define LBE_PCT_FULL        8'h64
`define LBE_STREAK_LEN      2'h3

// Timing: monitor tick period in microseconds at the clock rate
`define LBE_CLK_MHZ         100
`define LBE_TICK_US         1000
`define LBE_TICK_CYCLES     (`LBE_TICK_US * `LBE_CLK_MHZ)

`endif

// ---- design/lbe_pkg.sv ----
// Types shared by the board error status block.
// Assumes lbe_regs.svh on the include path.
`default_nettype none

package lbe_pkg;

  // Token monitor states
  typedef enum logic {
    LBE_TOK_IDLE,
    LBE_TOK_WAIT
  } lbe_tok_state_t;

endpackage : lbe_pkg

`default_nettype wire

// ---- design/lbe_streak_if.sv ----
// Carrier between the top module and a consecutive-cycle detector.
// Assumes one source and one detector per instance.
`default_nettype none

interface lbe_streak_if;
  logic cycle_end;
  logic over;
  logic hit;
  modport src (output cycle_end, output over, input hit);
  modport det (input cycle_end, input over, output hit);
endinterface : lbe_streak_if

`default_nettype wire

// ---- design/lbe_streak.sv ----
// Detector for a condition that holds over consecutive operation cycles.
// Assumes cycle_end is a one-cycle pulse, over sampled with it.
`default_nettype none
`include "lbe_regs.svh"

module lbe_streak
  import lbe_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst_n,
  lbe_streak_if.det  mon
);

  logic [1:0] run_cnt;

  // ------------------------------------------------------------
  // Run length of the condition, saturating at the limit
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_cnt <= 2'h0;
    end else if (mon.cycle_end) begin
      if (!mon.over) begin
        run_cnt <= 2'h0;
      end else if (run_cnt != `LBE_STREAK_LEN) begin
        run_cnt <= run_cnt + 2'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Hit pulse one clock after the cycle_end that completes the run
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mon.hit <= 1'b0;
    end else begin
      mon.hit <= mon.cycle_end && mon.over && (run_cnt == `LBE_STREAK_LEN - 2'h1);
    end
  end

endmodule : lbe_streak

`default_nettype wire

// ---- design/lbe_token_mon.sv ----
// Watch for the return of the cyclic area access token.
// Assumes tick is a one-cycle pulse per monitor time unit.
`default_nettype none
`include "lbe_regs.svh"

module lbe_token_mon
  import lbe_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        tick,
  input  wire logic        token_given,
  input  wire logic        token_returned,
  input  wire logic [15:0] limit,
  output logic             timeout
);

  lbe_tok_state_t state;
  logic [15:0]    elapsed;

  // ------------------------------------------------------------
  // Wait state and elapsed time; a zero limit blocks a new watch and times out a running one at the next tick
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state   <= LBE_TOK_IDLE;
      elapsed <= 16'h0000;
      timeout <= 1'b0;
    end else begin
      timeout <= 1'b0;
      case (state)
        LBE_TOK_IDLE: begin
          elapsed <= 16'h0000;
          if (token_given && !token_returned && limit != 16'h0000) begin
            state <= LBE_TOK_WAIT;
          end
        end
        LBE_TOK_WAIT: begin
          if (token_returned) begin
            state <= LBE_TOK_IDLE;
          end else if (tick) begin
            if (elapsed + 16'h0001 >= limit) begin
              timeout <= 1'b1;
              state   <= LBE_TOK_IDLE;
            end else begin
              elapsed <= elapsed + 16'h0001;
            end
          end
        end
        default: begin
          state <= LBE_TOK_IDLE;
        end
      endcase
    end
  end

endmodule : lbe_token_mon

`default_nettype wire

// ---- design/lbe_top.sv ----
// Error detail status word of a loop control board, read by the host CPU.
// Assumes all inputs synchronous to clk; condition inputs come from the
// board's own watchdog, bus interface, scheduler and start-up checker.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`default_nettype none
`include "lbe_regs.svh"

// Function
// - Bit 00 is one while the watchdog reports the loop controller faulty.
// - Bit 01 is set on a transfer error of the host bus.
// - Bit 02 is set when the token is not back within monitor time.
// - Bit 03 is set when the cold start flash parameter check fails.
// - In duplex mode, bit 03 is also set on all-block RAM database corruption.
// - Bit 04 is set while the host CPU type does not support the board.
// - Bit 08 is set when load exceeds 80 percent three cycles running.
// - Duplex: bit 09 set when host cycle exceeds 30 percent three cycles.
// - A fatal board error sets the summary fatal flag; the host stops.
// - Fatal causes sit in bits 00 to 03, non-fatal in 04 to 15.
// - Summary non-fatal flag clears with the error; loop control stops meanwhile.
module lbe_top
  import lbe_pkg::*;
#(
  parameter int TICK_CYCLES = `LBE_TICK_CYCLES
)
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Register port
  input  wire logic [`LBE_ADDR_W-1:0] reg_addr,
  input  wire logic [`LBE_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [`LBE_DATA_W-1:0] reg_rdata,
  // Board conditions
  input  wire logic                   watchdog_fault,
  input  wire logic                   bus_xfer_err,
  input  wire logic                   token_given,
  input  wire logic                   token_returned,
  input  wire logic                   cold_start,
  input  wire logic                   flash_check_done,
  input  wire logic                   flash_check_bad,
  input  wire logic                   duplex_mode,
  input  wire logic                   ram_db_all_bad,
  input  wire logic                   host_unsupported,
  input  wire logic                   cycle_end,
  input  wire logic [7:0]             load_pct,
  input  wire logic [15:0]            host_cycle_time,
  input  wire logic [15:0]            min_op_cycle,
  // Status outputs
  output logic [`LBE_DATA_W-1:0]      board_error_detail_word,
  output logic                        fatal_flag,
  output logic                        nonfatal_flag,
  output logic                        host_stop,
  output logic                        loop_stop,
  output logic                        irq
);

  localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

  logic [15:0]  mon_time;
  logic [15:0]  int_stat;
  logic [15:0]  int_mask;
  logic [15:0]  err_prev;
  logic [16:0]  tick_cnt;
  logic         tick;
  logic         token_timeout;
  logic         err_clear;
  logic [15:0]  next_err;
  logic [15:0]  err_rise;
  logic [23:0]  host_scaled;
  logic [23:0]  opcyc_scaled;
  logic         wr_stat;
  logic         wr_ctrl;
  logic         wr_mon_time;
  logic         wr_mask;
  logic [15:0]  err_cause;
  logic [15:0]  next_rdata;

  lbe_streak_if load_if ();
  lbe_streak_if opcyc_if ();

  // ------------------------------------------------------------
  // Register write decode
  // ------------------------------------------------------------
  assign wr_stat     = reg_wr && (reg_addr == `LBE_OFS_INT_STAT);
  assign wr_ctrl     = reg_wr && (reg_addr == `LBE_OFS_CTRL);
  assign wr_mon_time = reg_wr && (reg_addr == `LBE_OFS_MON_TIME);
  assign wr_mask     = reg_wr && (reg_addr == `LBE_OFS_INT_MASK);
  assign err_clear   = wr_ctrl && reg_wdata[`LBE_CTRL_CLEAR];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mon_time <= `LBE_MON_TIME_RST;
    end else if (wr_mon_time) begin
      mon_time <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_mask <= `LBE_INT_MASK_RST;
    end else if (wr_mask) begin
      int_mask <= reg_wdata;
    end
  end

  // ------------------------------------------------------------
  // Monitor time base
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_cnt <= 17'h00000;
    end else if (tick_cnt >= TICK_LAST) begin
      tick_cnt <= 17'h00000;
    end else begin
      tick_cnt <= tick_cnt + 17'h00001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt >= TICK_LAST);
    end
  end

  // ------------------------------------------------------------
  // Token return watch
  // ------------------------------------------------------------
  lbe_token_mon u_token_mon (
    .clk            (clk),
    .rst_n          (rst_n),
    .tick           (tick),
    .token_given    (token_given),
    .token_returned (token_returned),
    .limit          (mon_time),
    .timeout        (token_timeout)
  );

  // ------------------------------------------------------------
  // Three-cycle load and operation cycle detectors
  // ------------------------------------------------------------
  assign host_scaled  = 24'(host_cycle_time) * 24'(`LBE_PCT_FULL);
  assign opcyc_scaled = 24'(min_op_cycle) * 24'(`LBE_HOST_LIMIT_PCT);

  assign load_if.cycle_end  = cycle_end;
  assign load_if.over       = load_pct > `LBE_LOAD_LIMIT_PCT;
  assign opcyc_if.cycle_end = cycle_end && duplex_mode;
  assign opcyc_if.over      = duplex_mode && (host_scaled > opcyc_scaled);

  lbe_streak u_load_streak (
    .clk   (clk),
    .rst_n (rst_n),
    .mon   (load_if)
  );

  lbe_streak u_opcyc_streak (
    .clk   (clk),
    .rst_n (rst_n),
    .mon   (opcyc_if)
  );

  // ------------------------------------------------------------
  // Causes raised this cycle
  // ------------------------------------------------------------
  always_comb begin
    err_cause = 16'h0000;
    if (bus_xfer_err) begin
      err_cause[`LBE_BIT_BUS] = 1'b1;
    end
    if (token_timeout) begin
      err_cause[`LBE_BIT_CYCLIC] = 1'b1;
    end
    if (cold_start && flash_check_done && flash_check_bad) begin
      err_cause[`LBE_BIT_DATA] = 1'b1;
    end
    if (duplex_mode && ram_db_all_bad) begin
      err_cause[`LBE_BIT_DATA] = 1'b1;
    end
    if (load_if.hit) begin
      err_cause[`LBE_BIT_LOAD] = 1'b1;
    end
    if (opcyc_if.hit) begin
      err_cause[`LBE_BIT_OPCYC] = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Next error word; a new cause wins over a clear
  // ------------------------------------------------------------
  always_comb begin
    next_err = board_error_detail_word;
    if (err_clear) begin
      next_err = 16'h0000;
    end
    next_err = next_err | err_cause;
    next_err[`LBE_BIT_WATCHDOG] = watchdog_fault;
    next_err[`LBE_BIT_HOST]     = host_unsupported;
    next_err[7:5]   = 3'h0;
    next_err[15:10] = 6'h00;
  end

  // ------------------------------------------------------------
  // Error word and summary flags
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      board_error_detail_word <= 16'h0000;
    end else begin
      board_error_detail_word <= next_err;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fatal_flag <= 1'b0;
    end else begin
      fatal_flag <= |next_err[`LBE_FATAL_MSB:`LBE_FATAL_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nonfatal_flag <= 1'b0;
    end else begin
      nonfatal_flag <= |next_err[`LBE_NONFATAL_MSB:`LBE_NONFATAL_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      host_stop <= 1'b0;
    end else begin
      host_stop <= |next_err[`LBE_FATAL_MSB:`LBE_FATAL_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loop_stop <= 1'b0;
    end else begin
      loop_stop <= |next_err;
    end
  end

  // ------------------------------------------------------------
  // Interrupt status on each newly raised error bit
  // ------------------------------------------------------------
  assign err_rise = next_err & ~err_prev;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_prev <= 16'h0000;
    end else begin
      err_prev <= next_err;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_stat <= 16'h0000;
    end else if (wr_stat) begin
      int_stat <= (int_stat & ~reg_wdata) | err_rise;
    end else begin
      int_stat <= int_stat | err_rise;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat & int_mask);
    end
  end

  // ------------------------------------------------------------
  // Read data, valid only in the cycle after the read strobe
  // ------------------------------------------------------------
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        `LBE_OFS_ERR_WORD: begin
          next_rdata = board_error_detail_word;
        end
        `LBE_OFS_SUMMARY: begin
          next_rdata = {14'h0000, nonfatal_flag, fatal_flag};
        end
        `LBE_OFS_MON_TIME: begin
          next_rdata = mon_time;
        end
        `LBE_OFS_INT_STAT: begin
          next_rdata = int_stat;
        end
        `LBE_OFS_INT_MASK: begin
          next_rdata = int_mask;
        end
        default: begin
          next_rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule : lbe_top

`default_nettype wire

// ---- dv/lbe_monitor.sv ----
// Checker for the board error status block, watching only the top ports.
// Assumes one clock domain and a synchronous active-low reset.
`default_nettype none

module lbe_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        watchdog_fault,
  input wire logic        bus_xfer_err,
  input wire logic        cold_start,
  input wire logic        flash_check_done,
  input wire logic        flash_check_bad,
  input wire logic        duplex_mode,
  input wire logic        ram_db_all_bad,
  input wire logic        host_unsupported,
  input wire logic        cycle_end,
  input wire logic [7:0]  load_pct,
  input wire logic [15:0] board_error_detail_word,
  input wire logic        fatal_flag,
  input wire logic        nonfatal_flag,
  input wire logic        host_stop,
  input wire logic        loop_stop
);
  timeunit 1ns;
  timeprecision 1ns;

  wire [15:0] w = board_error_detail_word;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_WATCHDOG: assert property ($past(rst_n) |-> w[0] == $past(watchdog_fault))
    else $error("watchdog bit wrong");
  AST_BUS: assert property (bus_xfer_err |=> w[1])
    else $error("bus error bit not set");
  AST_CLR: assert property ($past(rst_n) && $fell(w[1]) |->
    $past(reg_wr && reg_addr == 8'h08 && reg_wdata[0])) else $error("bus bit lost");
  AST_FLASH: assert property (cold_start && flash_check_done && flash_check_bad |=> w[3])
    else $error("flash bit not set");
  AST_RAM: assert property (duplex_mode && ram_db_all_bad |=> w[3])
    else $error("database bit not set");
  AST_HOST: assert property ($past(rst_n) |-> w[4] == $past(host_unsupported))
    else $error("host bit wrong");
  AST_LOAD: assert property ($rose(w[8]) |-> $past(cycle_end, 2) && $past(load_pct, 2) > 8'h50)
    else $error("load bit without cause");
  AST_OPC: assert property ($rose(w[9]) |-> $past(cycle_end, 2) && $past(duplex_mode, 2))
    else $error("cycle bit without cause");
  AST_SUM: assert property (fatal_flag == (|w[3:0]) && host_stop == fatal_flag)
    else $error("fatal summary wrong");
  AST_NONF: assert property (nonfatal_flag == (|w[15:4]) && loop_stop == (|w))
    else $error("non-fatal summary wrong");
  AST_ZERO: assert property (w[7:5] == 3'h0 && w[15:10] == 6'h00)
    else $error("unused bits set");
endmodule : lbe_monitor

bind lbe_top lbe_monitor lbe_monitor_i (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
  .watchdog_fault, .bus_xfer_err, .cold_start, .flash_check_done, .flash_check_bad,
  .duplex_mode, .ram_db_all_bad, .host_unsupported, .cycle_end, .load_pct,
  .board_error_detail_word, .fatal_flag, .nonfatal_flag, .host_stop, .loop_stop);

`default_nettype wire

// ---- dv/lbe_host_model.sv ----
// Host CPU model: one-cycle reads and writes on the register port.
// Assumes read data are taken by the bench in the cycle after the strobe.
`default_nettype none

module lbe_host_model (
  input  wire logic   clk,
  output logic [7:0]  reg_addr,
  output logic [15:0] reg_wdata,
  output logic        reg_wr,
  output logic        reg_rd
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= w;
    reg_rd    <= !w;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    // Released data must not keep showing the last value
    reg_wdata <= ~d;
  endtask : xfer
endmodule : lbe_host_model

`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the board error status block.
// Assumes the host model drives the register port and the checker is bound.
`default_nettype none
`include "lbe_regs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst_n = 1'b0, reg_wr, reg_rd, rd_q = 1'b0, irq;
  logic        watchdog_fault = 1'b0, bus_xfer_err = 1'b0, token_given = 1'b0;
  logic        token_returned = 1'b0, cold_start = 1'b0, flash_check_done = 1'b0;
  logic        flash_check_bad = 1'b0, duplex_mode = 1'b0, ram_db_all_bad = 1'b0;
  logic        host_unsupported = 1'b0, cycle_end = 1'b0;
  logic        fatal_flag, nonfatal_flag, host_stop, loop_stop;
  logic [7:0]  reg_addr, load_pct = 8'h00;
  logic [15:0] reg_wdata, reg_rdata, board_error_detail_word, exp_q[$];
  logic [15:0] host_cycle_time = 16'h0000, min_op_cycle = 16'h0064;
  int          err_count = 0, n_compared = 0, seed = 32'h9E0E;

  lbe_top #(.TICK_CYCLES(10)) lbe_top_i (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .watchdog_fault, .bus_xfer_err, .token_given, .token_returned,
    .cold_start, .flash_check_done, .flash_check_bad, .duplex_mode, .ram_db_all_bad,
    .host_unsupported, .cycle_end, .load_pct, .host_cycle_time, .min_op_cycle,
    .board_error_detail_word, .fatal_flag, .nonfatal_flag, .host_stop, .loop_stop, .irq);
  lbe_host_model lbe_host_model_i (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic cmp(input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t exp %h got %h", $time, e, g);
    end
  endtask : cmp

  task automatic rdx(input logic [7:0] a, input logic [15:0] e);
    repeat (3) @(posedge clk);
    exp_q.push_back(e);
    lbe_host_model_i.xfer(1'b0, a, 16'h0000);
  endtask : rdx

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    lbe_host_model_i.xfer(1'b1, a, d);
  endtask : wr

  task automatic irq_is(input logic e);
    @(negedge clk);
    cmp({15'h0000, e}, {15'h0000, irq});
  endtask : irq_is

  task automatic bus_err;
    @(posedge clk) bus_xfer_err <= 1'b1;
    @(posedge clk) bus_xfer_err <= 1'b0;
  endtask : bus_err

  task automatic cyc(input logic [7:0] ld, input logic [15:0] hc);
    @(posedge clk);
    load_pct <= ld;
    host_cycle_time <= hc;
    cycle_end <= 1'b1;
    @(posedge clk) cycle_end <= 1'b0;
  endtask : cyc

  function automatic logic [7:0] rnd;
    return 8'h51 + 8'({$random(seed)} % 175);
  endfunction : rnd

  task automatic wrap_up;
    $display("TB: errors %0d, compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    rd_q <= reg_rd;
    if (rd_q)
      cmp(exp_q.pop_front(), reg_rdata);
  end

  initial begin
    #200000;
    err_count++;
    wrap_up();
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rdx(`LBE_OFS_ERR_WORD, 16'h0000);
    rdx(`LBE_OFS_MON_TIME, `LBE_MON_TIME_RST);
    rdx(8'h20, 16'h0000);
    @(posedge clk) watchdog_fault <= 1'b1;
    rdx(`LBE_OFS_ERR_WORD, 16'h0001);
    rdx(`LBE_OFS_SUMMARY, 16'h0001);
    @(posedge clk) watchdog_fault <= 1'b0;
    rdx(`LBE_OFS_ERR_WORD, 16'h0000);
    wr(`LBE_OFS_INT_MASK, 16'h0002);
    bus_err();
    rdx(`LBE_OFS_ERR_WORD, 16'h0002);
    irq_is(1'b1);
    wr(`LBE_OFS_CTRL, 16'h0001);
    wr(`LBE_OFS_INT_STAT, 16'h0002);
    rdx(`LBE_OFS_ERR_WORD, 16'h0000);
    irq_is(1'b0);
    wr(`LBE_OFS_INT_MASK, 16'h0000);
    bus_err();
    rdx(`LBE_OFS_INT_STAT, 16'h0003);
    irq_is(1'b0);
    wr(`LBE_OFS_CTRL, 16'h0001);
    wr(`LBE_OFS_MON_TIME, 16'h0002);
    rdx(`LBE_OFS_MON_TIME, 16'h0002);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) token_given <= 1'b1;
      @(posedge clk) token_given <= 1'b0;
      repeat (5) @(posedge clk);
      token_returned <= (k == 0);
      @(posedge clk) token_returned <= 1'b0;
      repeat (40) @(posedge clk);
      rdx(`LBE_OFS_ERR_WORD, (k == 0) ? 16'h0000 : 16'h0004);
    end
    wr(`LBE_OFS_CTRL, 16'h0001);
    @(posedge clk) cold_start <= 1'b1;
    flash_check_bad <= 1'b1;
    @(posedge clk) flash_check_done <= 1'b1;
    @(posedge clk) flash_check_done <= 1'b0;
    cold_start <= 1'b0;
    rdx(`LBE_OFS_ERR_WORD, 16'h0008);
    wr(`LBE_OFS_CTRL, 16'h0001);
    @(posedge clk) ram_db_all_bad <= 1'b1;
    rdx(`LBE_OFS_ERR_WORD, 16'h0000);
    @(posedge clk) ram_db_all_bad <= 1'b0;
    host_unsupported <= 1'b1;
    rdx(`LBE_OFS_ERR_WORD, 16'h0010);
    rdx(`LBE_OFS_SUMMARY, 16'h0002);
    @(posedge clk) host_unsupported <= 1'b0;
    rdx(`LBE_OFS_SUMMARY, 16'h0000);
    for (int i = 0; i < 5; i++)
      cyc((i == 2) ? 8'h50 : rnd(), 16'h0000);
    rdx(`LBE_OFS_ERR_WORD, 16'h0000);
    cyc(rnd(), 16'h0000);
    rdx(`LBE_OFS_ERR_WORD, 16'h0100);
    wr(`LBE_OFS_CTRL, 16'h0001);
    repeat (3) cyc(8'h00, 16'h001F);
    rdx(`LBE_OFS_ERR_WORD, 16'h0000);
    @(posedge clk) duplex_mode <= 1'b1;
    for (int i = 0; i < 5; i++)
      cyc(8'h00, (i == 2) ? 16'h001E : 16'h001F);
    rdx(`LBE_OFS_ERR_WORD, 16'h0000);
    cyc(8'h00, 16'h001F);
    rdx(`LBE_OFS_ERR_WORD, 16'h0200);
    @(posedge clk) ram_db_all_bad <= 1'b1;
    rdx(`LBE_OFS_ERR_WORD, 16'h0208);
    wrap_up();
  end
endmodule : tb

`default_nettype wire
